// File: logic/gsr_top.sv
// gateway system register bank: master words and four slave groups over APB
// Operation
// (R1) identity word is read-only; writes leave it unchanged
// (R2) firmware word is read-only: main revision bits 7..4, sub revision 3..0
// (R3) setup bits 1..0 select line one, line two or smart mode
// (R4) setup bit 2 selects 50 or 60 Hz mains; bits 15..3 reserved
// (R5) routing word holds four 2-bit repeater fields at 1..0,4..3,7..6,10..9
// (R6) routing bits 14..12 hold the number of installed repeaters
// (R7) each repeater picks one of four units independently, sharing allowed
// (R8) mapping codes 0..3 mean units 1..4
// (R9) status bits 1..0 name the unit that a calibration push addresses
// (R10) bits 6,7 show lines running, bit 13 override, bit 12 diagnostic mode
// (R11) status bits 8..11 are write-only command pulses
// (R12) station address sits in the low eight bits
// (R13) rate index bits 2..0 select 4800 up to 115200 baud
// (R14) host never programs a rate index above 5
// (R15) format index selects 8N1, 8E1, 8O1 or 8N2
// (R16) two error tallies count link and field errors; any write clears
// (R17) slave groups of 32 words at 0x420, 0x440, 0x460, 0x480
// (R18) slave registers at fixed offsets inside each group
// (R19) reserved words read zero and ignore writes
// (R20) real topology is read-only, wanted topology written, difference flagged
// (R21) topology bits 2..0 count expansion units, 16 channels each
// (R22) topology bits 7..4 give the unit type, zero when absent
// (R23) host programs station address only within 1..247
// (R24) identity code occupies bits 7..0 of the identity word
// (R25) line tallies count errors, read in diagnostic mode, clear on write
`timescale 1ns/100ps
module gsr_top #(
  parameter logic [7:0] IDENTITY_CODE = 8'h3c, // value is arbitrary
  parameter logic [3:0] REV_MAIN      = 4'h1,
  parameter logic [3:0] REV_SUB       = 4'h0
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  input  wire logic        PATH_ONE_ACTIVE,
  input  wire logic        PATH_TWO_ACTIVE,
  input  wire logic        PATH_FORCED_FLAG,
  input  wire logic        HOST_LINK_ERR,
  input  wire logic        FIELD_LINK_ERR,
  input  wire logic [3:0]  PATH1_ERR,
  input  wire logic [3:0]  PATH2_ERR,
  input  wire logic [63:0] SLAVE_REAL_TOPO,
  input  wire logic [63:0] SLAVE_FW_LEVEL,
  output      logic [1:0]  FIELD_PATH_SELECT,
  output      logic        MAINS_FREQUENCY_SEL,
  output      logic [2:0]  REPEATER_COUNT,
  output      logic [15:0] REP_SOURCE_UNIT,
  output      logic [1:0]  TARGET_UNIT_CODE,
  output      logic        DIAGNOSTIC_STATE,
  output      logic        RESTART_UNITS_CMD,
  output      logic        REBOOT_WHOLE_CMD,
  output      logic        CAL_READ_BACK_CMD,
  output      logic        CAL_PUSH_CMD,
  output      logic [7:0]  STATION_ADDRESS,
  output      logic [2:0]  LINK_RATE_INDEX,
  output      logic        PARITY_EN,
  output      logic        PARITY_ODD,
  output      logic        TWO_STOP,
  output      logic [63:0] WANTED_TOPO,
  output      logic [3:0]  TOPO_MISMATCH,
  output      logic [3:0]  UNIT_PRESENT,
  output      logic [11:0] UNIT_CHAN_BLOCKS
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire [10:0] idx       = PADDR[12:2];
  wire [5:0]  grp       = idx[10:5];
  wire [4:0]  off       = idx[4:0];
  wire [5:0]  grp_rel   = grp - gsr_pkg::GRP_SLAVE1;
  wire [1:0]  slv_idx   = grp_rel[1:0];
  wire        top_ok    = PADDR[15:13] == 3'b000;
  wire        mst_hit   = top_ok && grp == gsr_pkg::GRP_MASTER;
  wire        slv_hit   = top_ok && grp >= gsr_pkg::GRP_SLAVE1 && grp <= gsr_pkg::GRP_SLAVE4; // R17
  wire        setup_ph  = PSEL && !PENABLE;
  wire        access_ph = PSEL && PENABLE;
  wire        wr_acc    = access_ph && PWRITE;
  wire        mst_wr    = wr_acc && mst_hit;
  wire [15:0] wd        = PWDATA[15:0];
  wire [1:0]  strb      = PSTRB[1:0];

  wire wr_setup = mst_wr && off == gsr_pkg::IDX_SETUP[4:0];
  wire wr_rep   = mst_wr && off == gsr_pkg::IDX_ROUTING[4:0];
  wire wr_sts   = mst_wr && off == gsr_pkg::IDX_STATUS[4:0];
  wire wr_addr  = mst_wr && off == gsr_pkg::IDX_STATION[4:0];
  wire wr_rate  = mst_wr && off == gsr_pkg::IDX_RATE[4:0];
  wire wr_fmt   = mst_wr && off == gsr_pkg::IDX_FORMAT[4:0];
  wire wr_herr  = mst_wr && off == gsr_pkg::IDX_HOST_ERR[4:0];
  wire wr_ferr  = mst_wr && off == gsr_pkg::IDX_FIELD_ERR[4:0];

  // ---------------------------------------------------------------
  // master registers
  // ---------------------------------------------------------------
  logic [15:0] setup_r;
  logic [15:0] rep_r;
  logic [15:0] sts_r;
  logic [15:0] addr_r;
  logic [15:0] rate_r;
  logic [15:0] fmt_r;
  logic [3:0]  cmd_r;
  logic [3:0]  cmd_nxt;
  logic [15:0] rep_unit_r;
  logic [15:0] rep_unit_nxt;
  logic [2:0]  frame_r;
  logic [31:0] prdata_r;
  logic [15:0] host_tally;
  logic [15:0] field_tally;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      setup_r <= gsr_pkg::SETUP_RST;
      rep_r   <= gsr_pkg::REP_RST;
      sts_r   <= gsr_pkg::STS_RST;
      addr_r  <= gsr_pkg::ADDR_RST;
      rate_r  <= gsr_pkg::RATE_RST;
      fmt_r   <= gsr_pkg::FMT_RST;
    end else begin
      if (wr_setup) setup_r <= gsr_pkg::merge(setup_r, wd, strb, gsr_pkg::SETUP_WMASK); // R3 R4
      if (wr_rep) rep_r <= gsr_pkg::merge(rep_r, wd, strb, gsr_pkg::REP_WMASK); // R5 R6
      if (wr_sts) sts_r <= gsr_pkg::merge(sts_r, wd, strb, gsr_pkg::STS_WMASK); // R9 R10
      if (wr_addr) addr_r <= gsr_pkg::merge(addr_r, wd, strb, gsr_pkg::ADDR_WMASK); // R12
      if (wr_rate) rate_r <= gsr_pkg::merge(rate_r, wd, strb, gsr_pkg::RATE_WMASK); // R13
      if (wr_fmt) fmt_r <= gsr_pkg::merge(fmt_r, wd, strb, gsr_pkg::FMT_WMASK); // R15
    end
  end

  // command bits act once per write and are never stored
  assign cmd_nxt = (wr_sts && strb[1]) ? wd[gsr_pkg::STS_CMD_LSB +: 4] : 4'h0; // R11

  // repeater routing: code n selects unit n+1, one-hot per repeater
  for (genvar r = 0; r < 4; r++) begin : g_rep
    wire [1:0] code = rep_r[r*gsr_pkg::REP_STRIDE +: 2];
    assign rep_unit_nxt[r*4 +: 4] = 4'h1 << code; // R7 R8
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_r      <= 4'h0;
      rep_unit_r <= 16'h0000;
      frame_r    <= 3'b000;
    end else begin
      cmd_r      <= cmd_nxt; // R11
      rep_unit_r <= rep_unit_nxt; // R8
      frame_r    <= {fmt_r[1:0] == gsr_pkg::FMT_8N2, fmt_r[1:0] == gsr_pkg::FMT_8O1,
                     fmt_r[1:0] == gsr_pkg::FMT_8E1 || fmt_r[1:0] == gsr_pkg::FMT_8O1}; // R15
    end
  end

  gsr_err_tally #(.W(16)) u_host_tally (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .inc   (HOST_LINK_ERR),
    .clr   (wr_herr),
    .count (host_tally)
  ); // R16

  gsr_err_tally #(.W(16)) u_field_tally (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .inc   (FIELD_LINK_ERR),
    .clr   (wr_ferr),
    .count (field_tally)
  ); // R16

  // ---------------------------------------------------------------
  // slave groups
  // ---------------------------------------------------------------
  logic [15:0] slv_rd [gsr_pkg::NUM_SLAVES];

  for (genvar s = 0; s < gsr_pkg::NUM_SLAVES; s++) begin : g_slave
    gsr_slave_bank u_bank (
      .clk         (SYS_CLK),
      .rst_n       (RESETN),
      .wr_en       (wr_acc && slv_hit && slv_idx == 2'(s)),
      .off         (off),
      .wdata       (wd),
      .strb        (strb),
      .diag        (sts_r[gsr_pkg::STS_DIAG_BIT]),
      .real_topo   (SLAVE_REAL_TOPO[s*16 +: 16]),
      .fw_level    (SLAVE_FW_LEVEL[s*16 +: 16]),
      .path1_err   (PATH1_ERR[s]),
      .path2_err   (PATH2_ERR[s]),
      .rdata       (slv_rd[s]),
      .wanted_topo (WANTED_TOPO[s*16 +: 16]),
      .mismatch    (TOPO_MISMATCH[s]),
      .present     (UNIT_PRESENT[s]),
      .chan_blocks (UNIT_CHAN_BLOCKS[s*3 +: 3])
    ); // R18 R20
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] mst_rd;
  wire  [15:0] sts_view = {2'b00, PATH_FORCED_FLAG, sts_r[gsr_pkg::STS_DIAG_BIT], 4'h0,
                           PATH_TWO_ACTIVE, PATH_ONE_ACTIVE, 4'h0, sts_r[1:0]}; // R10 R11

  always_comb begin
    case (off)
      gsr_pkg::IDX_IDENTITY[4:0]:  mst_rd = {8'h00, IDENTITY_CODE}; // R1 R24
      gsr_pkg::IDX_FW_LEVEL[4:0]:  mst_rd = {8'h00, REV_MAIN, REV_SUB}; // R2
      gsr_pkg::IDX_SETUP[4:0]:     mst_rd = setup_r;
      gsr_pkg::IDX_ROUTING[4:0]:   mst_rd = rep_r;
      gsr_pkg::IDX_STATUS[4:0]:    mst_rd = sts_view;
      gsr_pkg::IDX_STATION[4:0]:   mst_rd = addr_r;
      gsr_pkg::IDX_RATE[4:0]:      mst_rd = rate_r;
      gsr_pkg::IDX_FORMAT[4:0]:    mst_rd = fmt_r;
      gsr_pkg::IDX_HOST_ERR[4:0]:  mst_rd = host_tally;
      gsr_pkg::IDX_FIELD_ERR[4:0]: mst_rd = field_tally;
      default:                     mst_rd = 16'h0000; // R19
    endcase
  end

  wire [15:0] rd_word = mst_hit ? mst_rd : slv_hit ? slv_rd[slv_idx] : 16'h0000;

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !PWRITE) begin
      prdata_r <= {16'h0000, rd_word};
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA              = prdata_r;
  assign PREADY              = 1'b1;
  assign PSLVERR             = access_ph && !mst_hit && !slv_hit;
  assign FIELD_PATH_SELECT   = setup_r[1:0]; // R3
  assign MAINS_FREQUENCY_SEL = setup_r[gsr_pkg::SETUP_FREQ_BIT]; // R4
  assign REPEATER_COUNT      = rep_r[gsr_pkg::REP_COUNT_LSB +: 3]; // R6
  assign REP_SOURCE_UNIT     = rep_unit_r;
  assign TARGET_UNIT_CODE    = sts_r[1:0]; // R9
  assign DIAGNOSTIC_STATE    = sts_r[gsr_pkg::STS_DIAG_BIT]; // R10
  assign RESTART_UNITS_CMD   = cmd_r[0];
  assign REBOOT_WHOLE_CMD    = cmd_r[1];
  assign CAL_READ_BACK_CMD   = cmd_r[2];
  assign CAL_PUSH_CMD        = cmd_r[3];
  assign STATION_ADDRESS     = addr_r[7:0]; // R12
  assign LINK_RATE_INDEX     = rate_r[2:0]; // R13
  assign PARITY_EN           = frame_r[0];
  assign PARITY_ODD          = frame_r[1];
  assign TWO_STOP            = frame_r[2];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  wire rd_acc = access_ph && !PWRITE && mst_hit;

  property p_identity;
    rd_acc && off == gsr_pkg::IDX_IDENTITY[4:0] |-> PRDATA == {24'h000000, IDENTITY_CODE};
  endproperty
  a_identity: assert property (p_identity) else $error("identity word wrong"); // R1

  property p_fw_level;
    rd_acc && off == gsr_pkg::IDX_FW_LEVEL[4:0] |-> PRDATA[15:0] == {8'h00, REV_MAIN, REV_SUB};
  endproperty
  a_fw_level: assert property (p_fw_level) else $error("firmware word wrong"); // R2

  property p_setup_write;
    wr_setup && strb[0] |=> FIELD_PATH_SELECT == $past(wd[1:0]) && MAINS_FREQUENCY_SEL == $past(wd[2]);
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup write not taken"); // R3

  property p_routing;
    wr_rep && strb == 2'b11 |-> ##2 REP_SOURCE_UNIT[15:12] == (4'h1 << $past(wd[10:9], 2))
      && REPEATER_COUNT == $past(wd[14:12], 2);
  endproperty
  a_routing: assert property (p_routing) else $error("repeater routing wrong"); // R8

  property p_cmd_pulse;
    wr_sts && strb[1] && wd[gsr_pkg::STS_CMD_LSB] |=> RESTART_UNITS_CMD ##1 !RESTART_UNITS_CMD;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("restart pulse not one cycle"); // R11

  property p_cmd_readzero;
    rd_acc && off == gsr_pkg::IDX_STATUS[4:0] |-> PRDATA[11:8] == 4'h0 && PRDATA[15:14] == 2'b00;
  endproperty
  a_cmd_readzero: assert property (p_cmd_readzero) else $error("command bits read back"); // R11

  property p_tally_clear;
    wr_herr && !HOST_LINK_ERR |=> host_tally == 16'h0000;
  endproperty
  a_tally_clear: assert property (p_tally_clear) else $error("host tally not cleared"); // R16

  property p_tally_count;
    !wr_herr && HOST_LINK_ERR && host_tally != 16'hffff |=> host_tally == $past(host_tally) + 16'h0001;
  endproperty
  a_tally_count: assert property (p_tally_count) else $error("host tally missed an error"); // R16

  property p_reserved;
    rd_acc && (off == 5'h05 || off == 5'h0b || off[4]) |-> PRDATA == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved word not zero"); // R19

  property p_format;
    wr_fmt && strb[0] && wd[1:0] == 2'b10 |-> ##2 PARITY_EN && PARITY_ODD && !TWO_STOP;
  endproperty
  a_format: assert property (p_format) else $error("odd parity format wrong"); // R15

  property p_station;
    wr_addr && strb[0] |=> STATION_ADDRESS == $past(wd[7:0]) ##1 $stable(STATION_ADDRESS) || $past(wr_addr);
  endproperty
  a_station: assert property (p_station) else $error("station address not stored"); // R12

  property p_status_flags;
    rd_acc && off == gsr_pkg::IDX_STATUS[4:0] |-> PRDATA[7] == $past(PATH_TWO_ACTIVE)
      && PRDATA[6] == $past(PATH_ONE_ACTIVE) && PRDATA[13] == $past(PATH_FORCED_FLAG);
  endproperty
  a_status_flags: assert property (p_status_flags) else $error("line flags not shown"); // R10

  property p_target_unit;
    wr_sts && strb[0] |=> TARGET_UNIT_CODE == $past(wd[1:0]);
  endproperty
  a_target_unit: assert property (p_target_unit) else $error("unit code not stored"); // R9

  property p_unmapped;
    access_ph && !PWRITE && !mst_hit && !slv_hit |-> PSLVERR && PRDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused"); // R17

  c_slave_write: cover property (wr_acc && slv_hit && slv_idx == 2'd3);
  c_push_cmd:    cover property (wr_sts && strb[1] && wd[11] ##1 CAL_PUSH_CMD);
  c_diag_read:   cover property (access_ph && !PWRITE && slv_hit && off == gsr_pkg::OFS_PATH1 && DIAGNOSTIC_STATE);
  c_unmapped:    cover property (PSLVERR);

endmodule

// File: logic/gsr_pkg.sv
// constants, types and helpers of the gateway system register bank
package gsr_pkg;

  // ---------------------------------------------------------------
  // master register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [10:0] IDX_IDENTITY  = 11'h400;
  localparam logic [10:0] IDX_FW_LEVEL  = 11'h401;
  localparam logic [10:0] IDX_SETUP     = 11'h402;
  localparam logic [10:0] IDX_ROUTING   = 11'h403;
  localparam logic [10:0] IDX_STATUS    = 11'h404;
  localparam logic [10:0] IDX_STATION   = 11'h408;
  localparam logic [10:0] IDX_RATE      = 11'h409;
  localparam logic [10:0] IDX_FORMAT    = 11'h40a;
  localparam logic [10:0] IDX_HOST_ERR  = 11'h40e;
  localparam logic [10:0] IDX_FIELD_ERR = 11'h40f;

  // ---------------------------------------------------------------
  // slave groups, 32 words each
  // ---------------------------------------------------------------
  localparam int          NUM_SLAVES  = 4;
  localparam logic [10:0] SLAVE_BASE1 = 11'h420;
  localparam logic [10:0] SLAVE_BASE2 = 11'h440;
  localparam logic [10:0] SLAVE_BASE3 = 11'h460;
  localparam logic [10:0] SLAVE_BASE4 = 11'h480;
  localparam logic [5:0]  GRP_MASTER  = IDX_IDENTITY[10:5];
  localparam logic [5:0]  GRP_SLAVE1  = SLAVE_BASE1[10:5];
  localparam logic [5:0]  GRP_SLAVE4  = SLAVE_BASE4[10:5];
  localparam logic [4:0]  OFS_REAL    = 5'h00;
  localparam logic [4:0]  OFS_FW      = 5'h01;
  localparam logic [4:0]  OFS_PATH1   = 5'h04;
  localparam logic [4:0]  OFS_PATH2   = 5'h05;
  // writable slots: wanted topology, offset, gain, resist, smoothing, junction
  localparam int          NUM_SLOTS   = 6;
  localparam logic [4:0]  SLOT_OFS [NUM_SLOTS] = '{5'h02, 5'h08, 5'h09, 5'h0a, 5'h0e, 5'h0f};
  localparam int          SLOT_WANTED = 0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SETUP_FREQ_BIT  = 2;
  localparam int REP_STRIDE      = 3;
  localparam int REP_COUNT_LSB   = 12;
  localparam int STS_ONE_BIT     = 6;
  localparam int STS_TWO_BIT     = 7;
  localparam int STS_CMD_LSB     = 8;
  localparam int STS_DIAG_BIT    = 12;
  localparam int STS_FORCED_BIT  = 13;
  localparam int TOPO_TYPE_LSB   = 4;

  // ---------------------------------------------------------------
  // writable bits and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SETUP_WMASK = 16'h0007;
  localparam logic [15:0] REP_WMASK   = 16'h76db;
  localparam logic [15:0] STS_WMASK   = 16'h1003;
  localparam logic [15:0] ADDR_WMASK  = 16'h00ff;
  localparam logic [15:0] RATE_WMASK  = 16'h0007;
  localparam logic [15:0] FMT_WMASK   = 16'h0003;
  localparam logic [15:0] SETUP_RST   = 16'h0000;
  localparam logic [15:0] REP_RST     = 16'h0000;
  localparam logic [15:0] STS_RST     = 16'h0000;
  localparam logic [15:0] ADDR_RST    = 16'h0001;
  localparam logic [15:0] RATE_RST    = 16'h0001;
  localparam logic [15:0] FMT_RST     = 16'h0000;
  localparam logic [15:0] SLOT_RST    = 16'h0000;

  typedef enum logic [1:0] {PATH_ONE = 2'b00, PATH_TWO = 2'b01, PATH_SMART = 2'b10} gsr_path_t;
  typedef enum logic [1:0] {FMT_8N1 = 2'b00, FMT_8E1 = 2'b01, FMT_8O1 = 2'b10, FMT_8N2 = 2'b11} gsr_fmt_t;

  // byte-lane merge of a 16-bit register, limited to its writable bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] strb, input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lane) | (wd & lane);
  endfunction

endpackage

// File: logic/gsr_err_tally.sv
// saturating error counter that any write clears
`timescale 1ns/100ps
module gsr_err_tally #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inc,
  input  wire logic         clr,
  output      logic [W-1:0] count
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // an error in the clearing cycle still counts
  assign count_nxt = clr ? {{(W-1){1'b0}}, inc} :
                     (inc && !(&count_r)) ? count_r + {{(W-1){1'b0}}, 1'b1} : count_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

// File: logic/gsr_slave_bank.sv
// register group of one field slave
`timescale 1ns/100ps
module gsr_slave_bank (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [4:0]  off,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  strb,
  input  wire logic        diag,
  input  wire logic [15:0] real_topo,
  input  wire logic [15:0] fw_level,
  input  wire logic        path1_err,
  input  wire logic        path2_err,
  output      logic [15:0] rdata,
  output      logic [15:0] wanted_topo,
  output      logic        mismatch,
  output      logic        present,
  output      logic [2:0]  chan_blocks
);

  logic [15:0]                   slot_r [gsr_pkg::NUM_SLOTS];
  logic [gsr_pkg::NUM_SLOTS-1:0] slot_hit;
  logic [15:0]                   tally1;
  logic [15:0]                   tally2;
  wire                           clr1 = wr_en && off == gsr_pkg::OFS_PATH1;
  wire                           clr2 = wr_en && off == gsr_pkg::OFS_PATH2;

  for (genvar i = 0; i < gsr_pkg::NUM_SLOTS; i++) begin : g_slot
    assign slot_hit[i] = off == gsr_pkg::SLOT_OFS[i];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        slot_r[i] <= gsr_pkg::SLOT_RST;
      end else if (wr_en && slot_hit[i]) begin
        slot_r[i] <= gsr_pkg::merge(slot_r[i], wdata, strb, 16'hffff);
      end
    end
  end

  gsr_err_tally #(.W(16)) u_path1 (.clk(clk), .rst_n(rst_n), .inc(path1_err), .clr(clr1), .count(tally1)); // R25
  gsr_err_tally #(.W(16)) u_path2 (.clk(clk), .rst_n(rst_n), .inc(path2_err), .clr(clr2), .count(tally2)); // R25

  always_comb begin
    rdata = 16'h0000; // R19
    if (off == gsr_pkg::OFS_REAL) rdata = real_topo; // R20
    if (off == gsr_pkg::OFS_FW) rdata = fw_level;
    if (off == gsr_pkg::OFS_PATH1 && diag) rdata = tally1; // R25
    if (off == gsr_pkg::OFS_PATH2 && diag) rdata = tally2; // R25
    for (int i = 0; i < gsr_pkg::NUM_SLOTS; i++) begin
      if (slot_hit[i]) rdata = slot_r[i]; // R18
    end
  end

  assign wanted_topo = slot_r[gsr_pkg::SLOT_WANTED];
  assign mismatch    = real_topo != wanted_topo; // R20
  assign present     = real_topo[gsr_pkg::TOPO_TYPE_LSB +: 4] != 4'h0; // R22
  assign chan_blocks = real_topo[2:0] + 3'd1; // R21

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_wanted_match;
    wr_en && slot_hit[gsr_pkg::SLOT_WANTED] && strb == 2'b11 && wdata == real_topo ##1 $stable(real_topo)
      |-> !mismatch;
  endproperty
  a_wanted_match: assert property (p_wanted_match) else $error("mismatch after matching wanted topology"); // R20

  property p_tally_hidden;
    !diag && (off == gsr_pkg::OFS_PATH1 || off == gsr_pkg::OFS_PATH2) |-> rdata == 16'h0000;
  endproperty
  a_tally_hidden: assert property (p_tally_hidden) else $error("line tally visible outside diagnostic mode"); // R25

endmodule

// File: verif/gsr_field_model.sv
// field-side stand-in: line flags and error pulses
`timescale 1ns/100ps
module gsr_field_model (
  input  wire logic       err_go,
  input  wire logic       flip,
  output      logic [2:0] lines,
  output      logic [9:0] errs
);
  // line one up, line two down, override set; flipped: only line two up
  assign lines = flip ? 3'b010 : 3'b101;
  assign errs  = {10{err_go}};
endmodule

// File: verif/gsr_top_bench.sv
// self-checking bench of the gateway system register bank
`timescale 1ns/100ps
module gateway_system_registers_bench;
  localparam logic [63:0] TOPO = 64'h0000_0023_0012_0031;
  localparam logic [63:0] FWL  = 64'h0004_0003_0002_0001;
  localparam logic [10:0] TALLY [4] = '{11'h40e, 11'h40f, 11'h424, 11'h445};
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err_go = 0, rdy, freq, diag, pe, po, two;
  logic        flip = 0, slverr, serr;
  logic [63:0] want;
  logic [2:0]  lines, rcnt, rate;
  logic [3:0]  cmd, mism, pres;
  logic [9:0]  errs;
  logic [1:0]  fsel, tcode;
  logic [7:0]  sta;
  logic [10:0] b;
  logic [11:0] blk;
  logic [15:0] paddr = '0, rep, v;
  logic [31:0] pwdata = '0, prdata, got;
  int          error_cnt = 0, checks_done = 0, cmd_cnt = 0;

  // identity code value is arbitrary
  gsr_top #(.IDENTITY_CODE(8'h5a)) i_dut (
    .SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(4'h3), .PRDATA(prdata), .PREADY(rdy), .PSLVERR(slverr),
    .PATH_ONE_ACTIVE(lines[0]), .PATH_TWO_ACTIVE(lines[1]), .PATH_FORCED_FLAG(lines[2]),
    .HOST_LINK_ERR(errs[0]), .FIELD_LINK_ERR(errs[1]), .PATH1_ERR(errs[5:2]), .PATH2_ERR(errs[9:6]),
    .SLAVE_REAL_TOPO(TOPO), .SLAVE_FW_LEVEL(FWL), .FIELD_PATH_SELECT(fsel), .MAINS_FREQUENCY_SEL(freq),
    .REPEATER_COUNT(rcnt), .REP_SOURCE_UNIT(rep), .TARGET_UNIT_CODE(tcode), .DIAGNOSTIC_STATE(diag),
    .RESTART_UNITS_CMD(cmd[0]), .REBOOT_WHOLE_CMD(cmd[1]), .CAL_READ_BACK_CMD(cmd[2]),
    .CAL_PUSH_CMD(cmd[3]), .STATION_ADDRESS(sta), .LINK_RATE_INDEX(rate), .PARITY_EN(pe),
    .PARITY_ODD(po), .TWO_STOP(two), .WANTED_TOPO(want), .TOPO_MISMATCH(mism), .UNIT_PRESENT(pres),
    .UNIT_CHAN_BLOCKS(blk));
  gsr_field_model i_fld (.err_go(err_go), .flip(flip), .lines(lines), .errs(errs));

  always @(posedge clk) cmd_cnt <= cmd_cnt + $countones(cmd);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [10:0] idx, input logic [15:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, 3'h0, idx, 2'h0, 16'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    got = prdata;
    serr = slverr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rd(input string nm, input logic [10:0] idx, input logic [15:0] e);
    xfer(1'b0, idx, 16'h0);
    chk(nm, got, {16'h0, e});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------
  // test sequence
  // ---------------
  initial forever #2 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd("station", 11'h408, 16'h0001);
    rd("rate", 11'h409, 16'h0001);
    xfer(1'b1, 11'h400, 16'hffff);
    rd("ident", 11'h400, 16'h005a);
    xfer(1'b1, 11'h401, 16'hffff);
    rd("fw", 11'h401, 16'h0010);
    for (int k = 0; k < 3; k++) begin
      v = 16'(k) | 16'((k & 1) << 2);
      xfer(1'b1, 11'h402, v | 16'hfff8);
      rd("setup", 11'h402, v);
      chk("path", fsel, k);
      chk("mains", freq, k & 1);
    end
    xfer(1'b1, 11'h403, 16'hffff);
    rd("route", 11'h403, 16'h76db);
    chk("rep_cnt", rcnt, 7);
    xfer(1'b1, 11'h403, 16'h4688);
    rd("route2", 11'h403, 16'h4688);
    chk("rep_src", rep, 32'h8421);
    xfer(1'b1, 11'h403, 16'h0492);
    rd("route3", 11'h403, 16'h0492);
    chk("rep_share", rep, 32'h4444);
    xfer(1'b1, 11'h404, 16'hffff);
    rd("status", 11'h404, 16'h3043);
    chk("cmds", cmd_cnt, 4);
    chk("unit", tcode, 3);
    chk("diag", diag, 1);
    flip <= 1'b1;
    rd("status2", 11'h404, 16'h1083);
    xfer(1'b1, 11'h408, 16'hfff7);
    rd("station", 11'h408, 16'h00f7);
    chk("sta", sta, 32'hf7);
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, 11'h409, 16'(k));
      rd("rate_rd", 11'h409, 16'(k));
      chk("rate", rate, k);
    end
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 11'h40a, 16'(k));
      rd("fmt", 11'h40a, 16'(k));
      chk("frame", {pe, po, two}, {k == 1 || k == 2, k == 2, k == 3});
    end
    @(posedge clk);
    err_go <= 1'b1;
    repeat (3) @(posedge clk);
    err_go <= 1'b0;
    foreach (TALLY[i]) begin
      rd("tally", TALLY[i], 16'h0003);
      xfer(1'b1, TALLY[i], 16'h1234);
      rd("tally_clr", TALLY[i], 16'h0000);
    end
    chk("mism", mism, 4'b0111);
    chk("present", pres, 4'b0111);
    chk("blocks", blk, 12'h31a);
    for (int s = 0; s < 4; s++) begin
      b = 11'h420 + 11'(32 * s);
      xfer(1'b1, b, 16'hffff);
      rd("real", b, TOPO[16*s +: 16]);
      rd("slv_fw", b + 11'h1, FWL[16*s +: 16]);
      xfer(1'b1, b + 11'h2, TOPO[16*s +: 16]);
      xfer(1'b1, b + 11'h3, 16'hffff);
      rd("rsv", b + 11'h3, 16'h0);
      xfer(1'b1, b + 11'h8, 16'ha5c0 ^ 16'(s));
      rd("trim", b + 11'h8, 16'ha5c0 ^ 16'(s));
    end
    chk("mism2", mism, 0);
    chk("want_lo", want[31:0], TOPO[31:0]);
    chk("want_hi", want[63:32], TOPO[63:32]);
    xfer(1'b1, 11'h405, 16'hffff);
    rd("rsv_m", 11'h405, 16'h0);
    chk("slverr0", serr, 0);
    xfer(1'b0, 11'h4a0, 16'h0);
    chk("slverr", serr, 1);
    chk("oor_rd", got, 0);
    give_verdict();
  end
endmodule
